/* File: pgen_period_timer.sv */
// Line period timer: pulses once every programmed period
`timescale 1ns/1ps
module pgen_period_timer import pgen_pkg::*; #(
	parameter int W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         restart,
	input  wire logic [W-1:0] period,
	output logic              tick
);
	localparam logic [7:0] SUB_MAX = 8'(PD_UNIT_CYC - 1);
	logic [W-1:0] units_q;
	logic [7:0]   sub_q;
	wire          unit_end = (sub_q == SUB_MAX);
	wire [W-1:0]  last_unit = (period == '0) ? '0 : period - W'(1);
	wire          at_end = unit_end && (units_q >= last_unit);

	// Count 10 ns units; a zero period is treated as one unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			units_q <= '0;
			sub_q   <= '0;
		end else if (restart || unit_end) begin
			sub_q   <= '0;
			units_q <= (restart || at_end) ? '0 : units_q + W'(1);
		end else begin
			sub_q   <= sub_q + 8'(1);
		end
	end

	assign tick = at_end && !restart;

	// A one-bit period could not tell a single unit from a zero period
	if (W < 2) begin
		$error("period width too small");
	end
endmodule

/* File: pgen_pixel_source.sv */
// Byte source: colour bars or fixed pattern block, one byte per step
`timescale 1ns/1ps
module pgen_pixel_source import pgen_pkg::*; #(
	parameter int LW = 16
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          line_start,
	input  wire logic          step,
	input  wire logic          fixed_mode,
	input  wire logic [1:0]    bars_sel,
	input  wire logic [3:0]    blk_last,
	input  wire logic [LW-1:0] bar_size,
	input  wire logic [127:0]  block,
	output logic [7:0]         byte_out
);
	logic [LW-1:0] bar_cnt_q;
	logic [2:0]    bar_q;
	logic [3:0]    idx_q;
	logic [2:0]    bar_last;
	logic [7:0]    bar_byte;
	logic [7:0]    fix_byte;

	// Number of bars minus one; last bar absorbs the line remainder
	assign bar_last = (bars_sel == 2'd0) ? 3'd0 : (bars_sel == 2'd1) ? 3'd1 :
			(bars_sel == 2'd2) ? 3'd3 : 3'd7;
	wire bar_end = (bar_cnt_q + LW'(1) >= bar_size) && (bar_q != bar_last);

	// With fewer bars, spread them over the eight colours
	wire [2:0] colour = (bars_sel == 2'd0) ? 3'd0 : (bars_sel == 2'd1) ? {bar_q[0], 2'b00} :
			(bars_sel == 2'd2) ? {bar_q[1:0], 1'b0} : bar_q;
	always_comb begin
		case (colour)
			3'd0:    bar_byte = BAR0;
			3'd1:    bar_byte = BAR1;
			3'd2:    bar_byte = BAR2;
			3'd3:    bar_byte = BAR3;
			3'd4:    bar_byte = BAR4;
			3'd5:    bar_byte = BAR5;
			3'd6:    bar_byte = BAR6;
			default: bar_byte = BAR7;
		endcase
	end
	// Odd bars send the inverted block
	assign fix_byte = block[idx_q*8 +: 8] ^ {8{bar_q[0]}};

	// Counters restart with every active line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bar_cnt_q <= '0;
			bar_q     <= '0;
			idx_q     <= '0;
		end else if (line_start) begin
			bar_cnt_q <= '0;
			bar_q     <= '0;
			idx_q     <= '0;
		end else if (step) begin
			bar_cnt_q <= bar_end ? '0 : bar_cnt_q + LW'(1);
			bar_q     <= bar_end ? bar_q + 3'd1 : bar_q;
			idx_q     <= (idx_q >= blk_last) ? 4'd0 : idx_q + 4'd1;
		end
	end

	assign byte_out = fixed_mode ? fix_byte : bar_byte;

	// Bar counter shares the sixteen-bit size field
	if (LW < 2 || LW > 16) begin
		$error("bar size width out of range");
	end
endmodule

/* File: pgen_pkg.sv */
// Constants, register map and types for the CSI-2 test pattern generator
// Contract
// - Two pattern kinds: reference colour bars and fixed colour pattern.
// - Bars one to three carry 0xAA, 0x33, 0xF0, each bar-length bytes.
// - Bars four to seven carry 0x7F, 0x55, 0xCC, 0x0F.
// - Eighth bar carries 0x80 and stretches to fill the line.
// - Bars per line selectable as one, two, four or eight.
// - Line byte count and bar byte length are independently programmable.
// - Datatype and virtual channel in headers come from software settings.
// - Programmable active lines within a programmable total line count.
// - Line spacing follows a programmable period in 10 ns units.
// - Front porch blank lines come after active lines, before frame end.
// - Back porch blank lines come after frame start, before active lines.
// - Runs in the transmit clock domain and hands formatted packets out.
// - Fixed mode uses the same frame and line geometry fields.
// - Fixed mode alternates bars between pattern and its bitwise inverse.
// - Fixed block length is programmable from one to sixteen bytes.
// - Sixteen byte registers hold the fixed pattern block.
package pgen_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFF      = 8'h00;
	localparam logic [7:0] CFG_OFF       = 8'h04;
	localparam logic [7:0] HDR_OFF       = 8'h08;
	localparam logic [7:0] LINE_SIZE_OFF = 8'h0C;
	localparam logic [7:0] BAR_SIZE_OFF  = 8'h10;
	localparam logic [7:0] ACT_LPF_OFF   = 8'h14;
	localparam logic [7:0] TOT_LPF_OFF   = 8'h18;
	localparam logic [7:0] LINE_PD_OFF   = 8'h1C;
	localparam logic [7:0] PORCH_OFF     = 8'h20;
	localparam logic [7:0] STATUS_OFF    = 8'h24;
	localparam logic [7:0] FIXED_OFF     = 8'h40;
	// Field positions
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_FIXED_BIT = 1;
	localparam int CFG_BARS_LSB   = 0;
	localparam int CFG_BLK_LSB    = 4;
	localparam int HDR_VC_LSB     = 6;
	localparam int PORCH_VFP_LSB  = 8;
	// Reset values
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [31:0] CFG_RST       = 32'h0000_0033;
	localparam logic [31:0] HDR_RST       = 32'h0000_0024;
	localparam logic [31:0] LINE_SIZE_RST = 32'h0000_0010;
	localparam logic [31:0] BAR_SIZE_RST  = 32'h0000_0002;
	localparam logic [31:0] ACT_LPF_RST   = 32'h0000_0004;
	localparam logic [31:0] TOT_LPF_RST   = 32'h0000_0008;
	localparam logic [31:0] LINE_PD_RST   = 32'h0000_0040;
	localparam logic [31:0] PORCH_RST     = 32'h0000_0000;
	// Line period unit and the cycles it covers at pclk
	localparam int PD_UNIT_NS    = 10;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PD_UNIT_CYC   = (PD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Short packet data identifiers
	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END   = 6'h01;
	// Bar colour table
	localparam logic [7:0] BAR0 = 8'hAA;
	localparam logic [7:0] BAR1 = 8'h33;
	localparam logic [7:0] BAR2 = 8'hF0;
	localparam logic [7:0] BAR3 = 8'h7F;
	localparam logic [7:0] BAR4 = 8'h55;
	localparam logic [7:0] BAR5 = 8'hCC;
	localparam logic [7:0] BAR6 = 8'h0F;
	localparam logic [7:0] BAR7 = 8'h80;
	// Frame sequencer states
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b000_0001,
		ST_FS    = 7'b000_0010,
		ST_HDR   = 7'b000_0100,
		ST_DATA  = 7'b000_1000,
		ST_BLANK = 7'b001_0000,
		ST_WAIT  = 7'b010_0000,
		ST_FE    = 7'b100_0000
	} seq_state_e;
endpackage

/* File: pgen_top.sv */
// APB-programmed CSI-2 test pattern generator, emitting packet bytes to the transmitter
`timescale 1ns/1ps
module pgen_top import pgen_pkg::*; #(
	parameter int LW = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [7:0]       tx_data,
	output logic             tx_valid,
	output logic             tx_sop,
	output logic             tx_eop,
	input  wire logic        tx_ready,
	output logic             frame_active
);
	// Word count in the header is sixteen bits, so wider counters would be cut
	if (LW < 8 || LW > 16) begin
		$error("LW must be 8..16");
	end

	// Register storage
	logic [31:0]  ctrl_q, cfg_q, hdr_q, lsize_q, bsize_q, act_q, tot_q, pd_q, porch_q;
	logic [127:0] block_q;
	logic         run_q;
	logic         fixed_q;
	logic [31:0]  frames_q;

	// APB decode; zero wait states, unmapped offsets answer with slave error
	wire        acc      = psel && penable;
	wire        wr       = acc && pwrite;
	wire        in_fixed = (paddr >= FIXED_OFF) && (paddr < FIXED_OFF + 8'h40);
	wire [3:0]  fix_idx  = paddr[5:2];
	wire        aligned  = (paddr[1:0] == 2'b00);
	wire        hit = aligned && (in_fixed || paddr == CTRL_OFF || paddr == CFG_OFF ||
			paddr == HDR_OFF || paddr == LINE_SIZE_OFF || paddr == BAR_SIZE_OFF ||
			paddr == ACT_LPF_OFF || paddr == TOT_LPF_OFF || paddr == LINE_PD_OFF ||
			paddr == PORCH_OFF || paddr == STATUS_OFF);
	wire        wr_ok    = wr && hit;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;

	// Register writes; geometry is latched per frame, but bar count, block length, fixed bytes and line period apply at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= CTRL_RST;
			cfg_q   <= CFG_RST;
			hdr_q   <= HDR_RST;
			lsize_q <= LINE_SIZE_RST;
			bsize_q <= BAR_SIZE_RST;
			act_q   <= ACT_LPF_RST;
			tot_q   <= TOT_LPF_RST;
			pd_q    <= LINE_PD_RST;
			porch_q <= PORCH_RST;
		end else if (wr_ok) begin
			case (paddr)
				CTRL_OFF:      ctrl_q  <= {30'd0, pwdata[1:0]};
				CFG_OFF:       cfg_q   <= {24'd0, pwdata[7:0]};
				HDR_OFF:       hdr_q   <= {24'd0, pwdata[7:0]};
				LINE_SIZE_OFF: lsize_q <= {16'd0, pwdata[15:0]};
				BAR_SIZE_OFF:  bsize_q <= {16'd0, pwdata[15:0]};
				ACT_LPF_OFF:   act_q   <= {16'd0, pwdata[15:0]};
				TOT_LPF_OFF:   tot_q   <= {16'd0, pwdata[15:0]};
				LINE_PD_OFF:   pd_q    <= {16'd0, pwdata[15:0]};
				PORCH_OFF:     porch_q <= {16'd0, pwdata[15:0]};
				default:       ctrl_q  <= ctrl_q;
			endcase
		end
	end

	// Sixteen fixed pattern byte registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_q <= '0;
		end else if (wr_ok && in_fixed) begin
			block_q[fix_idx*8 +: 8] <= pwdata[7:0];
		end
	end

	// Status word: running, mode in use, frames sent
	wire [31:0] status = {frames_q[15:0], 14'd0, fixed_q, run_q};
	always_comb begin
		case (paddr)
			CTRL_OFF:      prdata = ctrl_q;
			CFG_OFF:       prdata = cfg_q;
			HDR_OFF:       prdata = hdr_q;
			LINE_SIZE_OFF: prdata = lsize_q;
			BAR_SIZE_OFF:  prdata = bsize_q;
			ACT_LPF_OFF:   prdata = act_q;
			TOT_LPF_OFF:   prdata = tot_q;
			LINE_PD_OFF:   prdata = pd_q;
			PORCH_OFF:     prdata = porch_q;
			STATUS_OFF:    prdata = status;
			default:       prdata = in_fixed ? {24'd0, block_q[fix_idx*8 +: 8]} : 32'd0;
		endcase
		if (!aligned) begin
			prdata = 32'd0;
		end
	end

	// Frame sequencer
	seq_state_e    st_q, st_d;
	logic [LW-1:0] line_q;
	logic [LW-1:0] byte_q;
	logic [1:0]    hb_q;
	logic          started_q;
	logic [LW-1:0] f_lsize_q, f_act_q, f_tot_q, f_bsize_q;
	logic [7:0]    f_vbp_q, f_vfp_q;
	logic [7:0]    f_hdr_q;
	logic [7:0]    src_byte;
	logic [7:0]    out_d;

	wire            tick;
	wire            fire     = tx_valid && tx_ready;
	wire            en_req   = ctrl_q[CTRL_EN_BIT];
	// Lines run 0..tot_eff-1: back porch, then active lines, then remaining blanking
	wire [LW-1:0]   act_first = LW'(f_vbp_q);
	wire [LW-1:0]   act_end   = act_first + f_act_q;
	wire            line_act  = (line_q >= act_first) && (line_q < act_end);
	wire [LW-1:0]   tot_eff   = (f_tot_q < act_end + LW'(f_vfp_q)) ?
			act_end + LW'(f_vfp_q) : f_tot_q;
	wire            last_line = (line_q + LW'(1) >= tot_eff);
	wire            last_byte = (byte_q + LW'(1) >= f_lsize_q);
	wire            hdr_last  = (hb_q == 2'd3);
	wire            src_step  = fire && (st_q == ST_DATA);
	wire [LW-1:0]   line_nx   = line_q + LW'(1);
	wire            line_act_next = (line_nx >= act_first) && (line_nx < act_end);

	// Next state; each packet waits on transmitter ready
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:  st_d = (en_req) ? ST_FS : ST_IDLE;
			ST_FS:    st_d = (fire && hdr_last) ? ST_WAIT : ST_FS;
			ST_WAIT: begin
				if (tick && started_q) begin
					if (last_line) begin
						st_d = ST_FE;
					end else begin
						st_d = line_act_next ? ST_HDR : ST_BLANK;
					end
				end else if (tick) begin
					st_d = line_act ? ST_HDR : ST_BLANK;
				end
			end
			ST_HDR:   st_d = (fire && hdr_last) ? ST_DATA : ST_HDR;
			ST_DATA:  st_d = (fire && last_byte) ? ST_WAIT : ST_DATA;
			ST_BLANK: st_d = ST_WAIT;
			ST_FE:    st_d = (fire && hdr_last) ? ST_IDLE : ST_FE;
			default:  st_d = ST_IDLE;
		endcase
	end

	// Sequencer registers and per-frame capture of settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= ST_IDLE;
			line_q    <= '0;
			byte_q    <= '0;
			hb_q      <= '0;
			started_q <= 1'b0;
			run_q     <= 1'b0;
			fixed_q   <= 1'b0;
			frames_q  <= '0;
			f_lsize_q <= '0;
			f_act_q   <= '0;
			f_tot_q   <= '0;
			f_bsize_q <= '0;
			f_vbp_q   <= '0;
			f_vfp_q   <= '0;
			f_hdr_q   <= '0;
		end else begin
			st_q <= st_d;
			if (st_q == ST_IDLE) begin
				run_q     <= en_req;
				fixed_q   <= ctrl_q[CTRL_FIXED_BIT];
				f_lsize_q <= lsize_q[LW-1:0];
				f_act_q   <= act_q[LW-1:0];
				f_tot_q   <= tot_q[LW-1:0];
				f_bsize_q <= bsize_q[LW-1:0];
				f_vbp_q   <= porch_q[7:0];
				f_vfp_q   <= porch_q[PORCH_VFP_LSB +: 8];
				f_hdr_q   <= hdr_q[7:0];
				line_q    <= '0;
				started_q <= 1'b0;
			end
			if (fire && (st_q == ST_FS || st_q == ST_HDR || st_q == ST_FE)) begin
				hb_q <= hb_q + 2'd1;
			end
			if (src_step) begin
				byte_q <= last_byte ? '0 : byte_q + LW'(1);
			end
			if (st_q == ST_WAIT && tick) begin
				if (started_q) begin
					line_q <= line_nx;
				end
				started_q <= 1'b1;
			end
			if (st_q == ST_FE && fire && hdr_last) begin
				frames_q <= frames_q + 32'd1;
			end
		end
	end

	wire line_start = (st_q == ST_HDR) && (hb_q == 2'd0);
	pgen_pixel_source #(.LW(LW)) u_src (
		.pclk       (pclk),
		.presetn    (presetn),
		.line_start (line_start),
		.step       (src_step),
		.fixed_mode (fixed_q),
		.bars_sel   (cfg_q[CFG_BARS_LSB +: 2]),
		.blk_last   (cfg_q[CFG_BLK_LSB +: 4]),
		.bar_size   (f_bsize_q),
		.block      (block_q),
		.byte_out   (src_byte)
	);

	pgen_period_timer #(.W(16)) u_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (st_q == ST_IDLE),
		.period  (pd_q[15:0]),
		.tick    (tick)
	);

	// Packet header bytes: data id, word count low/high, check byte
	wire [5:0]  dt_sel  = (st_q == ST_FS) ? DT_FRAME_START :
			(st_q == ST_FE) ? DT_FRAME_END : f_hdr_q[5:0];
	wire [7:0]  di      = {f_hdr_q[HDR_VC_LSB +: 2], dt_sel};
	wire [15:0] wc      = (st_q == ST_HDR) ? 16'(f_lsize_q) : 16'd0;
	always_comb begin
		case (hb_q)
			2'd0:    out_d = di;
			2'd1:    out_d = wc[7:0];
			2'd2:    out_d = wc[15:8];
			default: out_d = di ^ wc[7:0] ^ wc[15:8];
		endcase
		if (st_q == ST_DATA) begin
			out_d = src_byte;
		end
	end

	// Byte stream to the transmitter
	assign tx_data  = out_d;
	assign tx_valid = (st_q == ST_FS) || (st_q == ST_HDR) || (st_q == ST_DATA) ||
			(st_q == ST_FE);
	assign tx_sop   = tx_valid && (st_q != ST_DATA) && (hb_q == 2'd0);
	assign tx_eop   = tx_valid && (((st_q == ST_FS || st_q == ST_FE) && hdr_last) ||
			((st_q == ST_DATA) && last_byte));
	assign frame_active = (st_q != ST_IDLE);
endmodule

/* File: pgen_top_assertions.sv */
// Port checker for the pattern generator
`timescale 1ns/1ps
module pgen_top_checker import pgen_pkg::*; #(
	parameter int LW = 16
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_sop,
	input wire logic        tx_eop,
	input wire logic        tx_ready,
	input wire logic        frame_active
);
	logic       first_q;
	logic [5:0] dt_q;
	logic [2:0] cnt_q;
	logic       take;
	logic       bad_addr;
	// Holes in the map and unaligned words are refused
	assign take     = tx_valid && tx_ready;
	assign bad_addr = (paddr[1:0] != 2'b00) || (paddr > 8'h24 && paddr < 8'h40) || (paddr > 8'h7C);
	// First byte of a frame, last packet type, bytes taken in a packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_q <= 1'b0;
			dt_q    <= '0;
			cnt_q   <= '0;
		end else begin
			first_q <= !frame_active || (first_q && !take);
			if (take && tx_sop) begin
				dt_q <= tx_data[5:0];
			end
			if (take) begin
				cnt_q <= tx_sop ? 3'h1 : cnt_q + 3'h1; // Wraps on long packets, unused there
			end
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take;
		tx_valid && tx_ready;
	endsequence
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	property p_hold;
		s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_sop) && $stable(tx_eop);
	endproperty
	property p_quiet;
		!frame_active |-> !tx_valid;
	endproperty
	property p_ready;
		psel && penable |-> pready;
	endproperty
	property p_err;
		psel && penable |-> pslverr == bad_addr;
	endproperty
	property p_err_read;
		psel && penable && !pwrite && bad_addr |-> prdata == 32'h0000_0000;
	endproperty
	property p_first_fs;
		s_take ##0 first_q |-> tx_sop && tx_data[5:0] == DT_FRAME_START;
	endproperty
	property p_last_fe;
		$fell(frame_active) |-> dt_q == DT_FRAME_END;
	endproperty
	property p_short;
		s_take ##0 (tx_eop && !tx_sop && dt_q < 6'h10) |-> cnt_q == 3'h3;
	endproperty
	a_hold: assert property (p_hold) else $error("stream byte changed while stalled");
	a_quiet: assert property (p_quiet) else $error("byte offered outside a frame");
	a_ready: assert property (p_ready) else $error("bus access not answered");
	a_err: assert property (p_err) else $error("error flag disagrees with address");
	a_err_read: assert property (p_err_read) else $error("refused read returned data");
	a_first_fs: assert property (p_first_fs) else $error("frame did not open with start");
	a_last_fe: assert property (p_last_fe) else $error("frame did not close with end");
	a_short: assert property (p_short) else $error("short packet length wrong");
endmodule
bind pgen_top pgen_top_checker #(.LW(LW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_sop(tx_sop),
	.tx_eop(tx_eop), .tx_ready(tx_ready), .frame_active(frame_active));

/* File: pgen_tx_sink.sv */
// Transmitter side model that takes generated bytes
`timescale 1ns/1ps
module pgen_tx_sink (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic stall,
	input  wire logic tx_valid,
	output logic      tx_ready
);
	// Ready changes only after an edge; random stalls test the hold rule
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= (stall && tx_valid) ? 1'($urandom % 2) : 1'b1;
		end
	end
endmodule

/* File: test_pgen_top.sv */
// Self-checking bench for the pattern generator
`timescale 1ns/1ps
module test_pgen_top import pgen_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stall;
	logic        tx_valid, tx_sop, tx_eop, tx_ready, frame_active;
	logic [7:0]  paddr, tx_data;
	logic [31:0] pwdata, prdata, rd;
	int          fails, comparisons, cyc, w, k, nb, bs, ls, bl, act, vbp, vfp, vc, dt, fx;
	logic [9:0]  got[$], exp[$];
	int          tsop[$];
	logic [7:0]  blk[16];
	logic [7:0]  tbl[8] = '{BAR0, BAR1, BAR2, BAR3, BAR4, BAR5, BAR6, BAR7};
	logic [31:0] rst[9] = '{CTRL_RST, CFG_RST, HDR_RST, LINE_SIZE_RST, BAR_SIZE_RST,
		ACT_LPF_RST, TOT_LPF_RST, LINE_PD_RST, PORCH_RST};
	int          bls[8] = '{5, 15, 9, 16, 1, 3, 12, 6};
	pgen_top #(.LW(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_sop(tx_sop),
		.tx_eop(tx_eop), .tx_ready(tx_ready), .frame_active(frame_active));
	pgen_tx_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall), .tx_valid(tx_valid),
		.tx_ready(tx_ready));
	always #5 pclk = ~pclk;
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// Monitor bytes taken; a hang is cut short by the cycle ceiling
	always @(posedge pclk) begin
		cyc++;
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			got.push_back({tx_sop, tx_eop, tx_data});
			if (tx_sop) tsop.push_back(cyc);
		end
		if (cyc > 60000) begin
			fails++;
			give_verdict();
		end
	end
	// One APB transfer, held until pready is seen
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task push(input logic s, input logic e, input logic [7:0] b);
		exp.push_back({s, e, b});
	endtask
	// Packet header of the model; short packets carry no payload
	task packet(input logic [7:0] di, input int wc);
		logic [7:0] lo, hi;
		lo = wc[7:0];
		hi = wc[15:8];
		push(1'b1, 1'b0, di);
		push(1'b0, 1'b0, lo);
		push(1'b0, 1'b0, hi);
		push(1'b0, wc == 0, di ^ lo ^ hi);
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, stall} = '0;
		void'($urandom(17568));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int j = 0; j < 9; j++) begin
			apb(1'b0, 8'(4 * j), 32'h0000_0000);
			check(rd, rst[j]);
		end
		apb(1'b1, 8'h28, 32'hFFFF_FFFF);
		check(err, 1'b1);
		apb(1'b0, 8'h28, 32'h0000_0000);
		check(err, 1'b1);
		check(rd, 32'h0000_0000);
		apb(1'b0, 8'h45, 32'h0000_0000);
		check(err, 1'b1);
		// Every bar count in both modes; lines long enough to reach the last bar
		for (int i = 0; i < 8; i++) begin
			fx = i % 2;
			nb = (i / 2) % 4;
			bl = bls[i];
			bs = 3 * (1 + $urandom % 2);
			ls = (1 << nb) * bs + $urandom % 8;
			act = 1 + $urandom % 3;
			vbp = $urandom % 3;
			vfp = $urandom % 3;
			vc = $urandom % 4;
			dt = 16 + $urandom % 48;
			stall = (i >= 2);
			for (int j = 0; j < 16; j++) begin
				blk[j] = 8'($urandom);
				apb(1'b1, 8'(FIXED_OFF + 4 * j), {24'h00_0000, blk[j]});
			end
			apb(1'b1, CFG_OFF, nb | ((bl - 1) << CFG_BLK_LSB));
			apb(1'b1, HDR_OFF, dt | (vc << HDR_VC_LSB));
			apb(1'b1, LINE_SIZE_OFF, ls);
			apb(1'b1, BAR_SIZE_OFF, bs);
			apb(1'b1, ACT_LPF_OFF, act);
			apb(1'b1, TOT_LPF_OFF, act + vbp + vfp + 1);
			apb(1'b1, LINE_PD_OFF, 120);
			apb(1'b1, PORCH_OFF, vbp | (vfp << PORCH_VFP_LSB));
			exp.delete();
			got.delete();
			tsop.delete();
			packet({vc[1:0], DT_FRAME_START}, 0);
			for (int l = 0; l < act; l++) begin
				packet({vc[1:0], dt[5:0]}, ls);
				for (int b = 0; b < ls; b++) begin
					k = b / bs;
					if (k > (1 << nb) - 1) k = (1 << nb) - 1;
					push(1'b0, b == ls - 1, fx ? blk[b % bl] ^ (k % 2 ? 8'hFF : 8'h00) : tbl[k << (3 - nb)]);
				end
			end
			packet({vc[1:0], DT_FRAME_END}, 0);
			apb(1'b1, CTRL_OFF, 1 | (fx << CTRL_FIXED_BIT));
			for (w = 0; w < 1000 && frame_active !== 1'b1; w++) @(posedge pclk);
			check(frame_active, 1'b1);
			apb(1'b1, CTRL_OFF, 32'h0000_0000);
			for (w = 0; w < 20000 && frame_active !== 1'b0; w++) @(posedge pclk);
			check(frame_active, 1'b0);
			repeat (300) @(posedge pclk);
			check(got.size(), exp.size());
			for (int j = 0; j < exp.size(); j++)
				check(got[j], exp[j]);
			check(tsop.size() > 1 && tsop[1] - tsop[0] >= vbp * 120, 1'b1);
			check(tsop.size() > 1 && tsop[$] - tsop[$ - 1] >= vfp * 120, 1'b1);
			// One frame per enable, generator idle and in bar mode after disable
			apb(1'b0, STATUS_OFF, 32'h0000_0000);
			check(rd, 32'((i + 1) << 16));
		end
		give_verdict();
	end
endmodule
